// File: dsps_pkg.sv
// constants, register map and carrier types of the deep standby power sequencer
// Contract
// - rtc-keeping mode runs only the sub oscillator; rtc, remote receiver, detector live.
// - rtc-keeping mode stops core and bus clocks, powers off core, flash, and sram unless retained.
// - entry loses core and sram contents unless retained; flash keeps its contents.
// - debug logic is stopped and unpowered during deep standby.
// - with retention configured the sram supply stays on; otherwise it is cut.
// - rtc, remote receiver, detector and this block stay powered, never reset.
// - transition reset clears port function selects except port 0 bits four to zero.
// - peripheral bus clocks stop; other peripherals off and reset; gpio stays powered.
// - all-stop mode stops every oscillator; only the detector keeps working.
// - pin level bit zero gives gpio pins, one gives high impedance pins.
// - one keyed write with select one and mode 2'b10 latches deep selection.
// - rtc-keeping mode wakes on reset pin, detector, rtc, remote or wake pin.
// - watchdog, supervisor and frequency resets are off and never wake.
// - every return waits for both internal rc oscillators to stabilise.
// - every return first waits for regulator settling, then starts return steps.
// - all-stop mode wakes on reset, detector or wake pin; rtc, remote ignored.
// - all-stop mode also wakes on a detector interrupt and resumes on fast rc.
// - mode fields are written only with key 16'h1ACC and cleared on resume; key always reads zero.
// - wake causes stay latched after return but go unserviced.
package dsps_pkg;

	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int CLK_MHZ     = 200;
	localparam int REG_WAIT_US = 300;
	localparam int OSC_WAIT_US = 100;
	localparam int REG_WAIT_CYC = REG_WAIT_US * CLK_MHZ;
	localparam int OSC_WAIT_CYC = OSC_WAIT_US * CLK_MHZ;
	localparam int TMR_W        = 17;

	//------------------------------------------------------------
	// register map
	//------------------------------------------------------------
	localparam int         ADDR_W            = 8;
	localparam logic [7:0] OFS_STANDBY_CTRL  = 8'h00;
	localparam logic [7:0] OFS_RTC_MODE_CTRL = 8'h04;
	localparam logic [7:0] OFS_WAKE_ENABLE   = 8'h08;
	localparam logic [7:0] OFS_RETENTION     = 8'h0C;
	localparam logic [7:0] OFS_WAKE_CAUSE    = 8'h10;
	localparam logic [7:0] OFS_STATUS        = 8'h14;

	localparam logic [15:0] UNLOCK_KEY = 16'h1ACC;
	localparam int          KEY_LSB    = 16;
	localparam int          PIN_LVL_B  = 4;
	localparam int          DEEP_SEL_B = 2;
	localparam logic [1:0]  MODE_DEEP  = 2'h2;
	localparam logic [1:0]  MODE_RST   = 2'h0;

	localparam int WEN_RTC    = 0;
	localparam int WEN_REMOTE = 1;
	localparam int WEN_LV     = 2;
	localparam int WEN_PIN    = 3;
	localparam int WEN_LVIRQ  = 4;
	localparam logic [4:0] WEN_RST = 5'h00;

	// wake cause bit order, also the synchroniser input order
	localparam int CS_EXT_RST = 0;
	localparam int CS_LV_RST  = 1;
	localparam int CS_LV_IRQ  = 2;
	localparam int CS_RTC     = 3;
	localparam int CS_REMOTE  = 4;
	localparam int CS_PIN     = 5;
	localparam int N_CAUSE    = 6;

	localparam logic [7:0] PORT0_KEEP_MASK = 8'h1F;

	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_RUN      = 6'h01,
		ST_ENTER    = 6'h02,
		ST_SLEEP    = 6'h04,
		ST_REG_WAIT = 6'h08,
		ST_OSC_WAIT = 6'h10,
		ST_RESUME   = 6'h20
	} dsps_state_t;

	typedef struct packed {
		logic hscr_osc_en;
		logic main_osc_en;
		logic pll_en;
		logic lscr_osc_en;
		logic sub_osc_en;
		logic core_clk_en;
		logic ahb_clk_en;
		logic apb_clk_en;
		logic core_pwr;
		logic flash_pwr;
		logic sram_pwr;
		logic periph_pwr;
		logic debug_pwr;
		logic aon_pwr;
		logic transition_rst;
		logic pins_hiz;
		logic pins_gpio;
		logic reg_low_power;
		logic sup_resets_en;
		logic hs_run;
	} dsps_ctrl_t;

	localparam dsps_ctrl_t CTRL_RUN = '{
		hscr_osc_en: 1'b1, main_osc_en: 1'b1, pll_en: 1'b1, lscr_osc_en: 1'b1,
		sub_osc_en: 1'b1, core_clk_en: 1'b1, ahb_clk_en: 1'b1, apb_clk_en: 1'b1,
		core_pwr: 1'b1, flash_pwr: 1'b1, sram_pwr: 1'b1, periph_pwr: 1'b1,
		debug_pwr: 1'b1, aon_pwr: 1'b1, transition_rst: 1'b0, pins_hiz: 1'b0,
		pins_gpio: 1'b0, reg_low_power: 1'b0, sup_resets_en: 1'b1, hs_run: 1'b0};

endpackage

// File: dsps_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module dsps_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	//------------------------------------------------------------
	// per bit stages
	//------------------------------------------------------------
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		logic meta;
		// first stage feeds only the second
		always_ff @(posedge i_ref_clk or posedge i_rst) begin
			if (i_rst) begin
				meta      <= 1'b0;
				o_sync[b] <= 1'b0;
			end else begin
				meta      <= i_async[b];
				o_sync[b] <= meta;
			end
		end
	end
endmodule
`default_nettype wire

// File: dsps_timer.sv
// one-shot wait timer with an expiry pulse
`timescale 1ns/10ps
`default_nettype none
module dsps_timer #(
	parameter int WIDTH = 17
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic             i_start,
	input  wire logic [WIDTH-1:0] i_cycles,
	output logic                  o_busy,
	output logic                  o_expire
);
	logic [WIDTH-1:0] count;
	wire              last = o_busy && (count == {{(WIDTH-1){1'b0}}, 1'b1});

	//------------------------------------------------------------
	// down counter
	//------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			count    <= '0;
			o_busy   <= 1'b0;
			o_expire <= 1'b0;
		end else if (i_start) begin
			count    <= i_cycles;
			o_busy   <= 1'b1;
			o_expire <= 1'b0;
		end else begin
			count    <= o_busy ? count - 1'b1 : count;
			o_busy   <= o_busy && !last;
			o_expire <= last;
		end
	end
endmodule
`default_nettype wire

// File: dsps_sequencer.sv
// deep standby power sequencer: registers, entry, sleep and return sequence
`timescale 1ns/10ps
`default_nettype none
module dsps_sequencer
	import dsps_pkg::*;
#(
	parameter int REG_WAIT_CYCLES = REG_WAIT_CYC,
	parameter int OSC_WAIT_CYCLES = OSC_WAIT_CYC,
	parameter bit HAS_RETENTION   = 1'b1
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	// register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_we,
	input  wire logic              i_re,
	output logic      [31:0]       o_rdata,
	// core side, same clock
	input  wire logic              i_core_deep_sleep_bit,
	input  wire logic              i_core_wait,
	output logic                   o_ordinary_standby_req,
	// asynchronous wake sources and sub oscillator ready
	input  wire logic              i_external_reset_pin_n,
	input  wire logic              i_lowvolt_reset,
	input  wire logic              i_lowvolt_irq,
	input  wire logic              i_rtc_irq,
	input  wire logic              i_remote_irq,
	input  wire logic              i_wake_pin,
	input  wire logic              i_sub_osc_ready,
	// power, clock and reset controls, port 0 keep mask and wake causes
	output dsps_ctrl_t             o_ctrl,
	output logic      [7:0]        o_port0_keep_mask,
	output logic      [N_CAUSE-1:0] o_wake_cause
);
	//------------------------------------------------------------
	// parameter checks
	//------------------------------------------------------------
	if (REG_WAIT_CYCLES < 1 || REG_WAIT_CYCLES >= (1 << TMR_W)) begin : g_chk_reg
		$error("regulator wait does not fit the timer");
	end
	if (OSC_WAIT_CYCLES < 1 || OSC_WAIT_CYCLES >= (1 << TMR_W)) begin : g_chk_osc
		$error("oscillator wait does not fit the timer");
	end

	//------------------------------------------------------------
	// synchronised inputs
	//------------------------------------------------------------
	logic [N_CAUSE:0] raw_async;
	logic [N_CAUSE:0] syncd;
	logic [N_CAUSE-1:0] src;
	logic             sub_rdy;

	assign raw_async = {i_sub_osc_ready, i_wake_pin, i_remote_irq, i_rtc_irq,
		i_lowvolt_irq, i_lowvolt_reset, ~i_external_reset_pin_n};

	dsps_sync #(.WIDTH(N_CAUSE + 1)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   (raw_async),
		.o_sync    (syncd)
	);

	assign src     = syncd[N_CAUSE-1:0];
	assign sub_rdy = syncd[N_CAUSE];

	//------------------------------------------------------------
	// registers and state
	//------------------------------------------------------------
	dsps_state_t      state;
	dsps_state_t      next_state;
	logic             pin_level;
	logic             deep_sel;
	logic [1:0]       mode_sel;
	logic             rtc_mode_enable;
	logic [4:0]       wake_en;
	logic             sram_retain;
	logic [N_CAUSE-1:0] cause;
	logic             sleep_rtc;
	dsps_ctrl_t       next_ctrl;

	//------------------------------------------------------------
	// register decode
	//------------------------------------------------------------
	wire hit_stb  = i_addr == OFS_STANDBY_CTRL;
	wire hit_rtcm = i_addr == OFS_RTC_MODE_CTRL;
	wire hit_wen  = i_addr == OFS_WAKE_ENABLE;
	wire hit_ret  = i_addr == OFS_RETENTION;
	wire hit_cs   = i_addr == OFS_WAKE_CAUSE;
	wire hit_st   = i_addr == OFS_STATUS;

	wire key_ok  = i_wdata[31:KEY_LSB] == UNLOCK_KEY;
	wire wr_stb  = i_we && hit_stb && key_ok;
	wire wr_rtcm = i_we && hit_rtcm && (!i_wdata[0] || sub_rdy);
	wire wr_wen  = i_we && hit_wen;
	wire wr_ret  = i_we && hit_ret;
	wire wr_cs   = i_we && hit_cs;

	wire deep_latched = deep_sel && (mode_sel == MODE_DEEP);

	//------------------------------------------------------------
	// wake qualification
	//------------------------------------------------------------
	// either enable keeps detector wakes
	wire lv_en = wake_en[WEN_LV] || wake_en[WEN_LVIRQ];
	logic [N_CAUSE-1:0] qual;
	always_comb begin
		qual = '0;
		qual[CS_EXT_RST] = src[CS_EXT_RST];
		qual[CS_LV_RST]  = src[CS_LV_RST];
		qual[CS_LV_IRQ]  = src[CS_LV_IRQ] && lv_en;
		qual[CS_PIN]     = src[CS_PIN] && wake_en[WEN_PIN];
		// rtc and remote only in rtc-keeping mode
		qual[CS_RTC]     = sleep_rtc && src[CS_RTC] && wake_en[WEN_RTC];
		qual[CS_REMOTE]  = sleep_rtc && src[CS_REMOTE] && wake_en[WEN_REMOTE];
	end

	// no watchdog or supervisor term here
	wire wake = (state == ST_SLEEP) && (|qual);

	//------------------------------------------------------------
	// wait timer
	//------------------------------------------------------------
	logic tmr_busy;
	logic tmr_expire;
	logic tmr_start;
	logic [TMR_W-1:0] tmr_cycles;

	assign tmr_start  = wake || (state == ST_REG_WAIT && tmr_expire);
	assign tmr_cycles = wake ? TMR_W'(REG_WAIT_CYCLES) : TMR_W'(OSC_WAIT_CYCLES);

	dsps_timer #(.WIDTH(TMR_W)) u_timer (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_start   (tmr_start),
		.i_cycles  (tmr_cycles),
		.o_busy    (tmr_busy),
		.o_expire  (tmr_expire)
	);

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	// deep entry only when selected
	wire sleep_req = i_core_wait && i_core_deep_sleep_bit;
	assign o_ordinary_standby_req = sleep_req && !deep_latched && (state == ST_RUN);

	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (sleep_req && deep_latched) begin
					next_state = ST_ENTER;
				end
			end
			ST_ENTER:    next_state = ST_SLEEP;
			ST_SLEEP: begin
				if (wake) begin
					next_state = ST_REG_WAIT;
				end
			end
			ST_REG_WAIT: begin
				if (tmr_expire) begin
					next_state = ST_OSC_WAIT;
				end
			end
			ST_OSC_WAIT: begin
				if (tmr_expire) begin
					next_state = ST_RESUME;
				end
			end
			ST_RESUME:   next_state = ST_RUN;
			default:     next_state = ST_RUN;
		endcase
	end

	//------------------------------------------------------------
	// power and clock controls per state
	//------------------------------------------------------------
	wire in_deep = state inside {ST_ENTER, ST_SLEEP, ST_REG_WAIT, ST_OSC_WAIT};

	always_comb begin
		next_ctrl = CTRL_RUN;
		if (in_deep) begin
			next_ctrl.core_clk_en    = 1'b0;
			next_ctrl.ahb_clk_en     = 1'b0;
			next_ctrl.apb_clk_en     = 1'b0;
			next_ctrl.periph_pwr     = 1'b0;
			next_ctrl.core_pwr       = 1'b0;
			next_ctrl.flash_pwr      = 1'b0;
			next_ctrl.sram_pwr       = HAS_RETENTION && sram_retain;
			next_ctrl.debug_pwr      = 1'b0;
			next_ctrl.aon_pwr        = 1'b1;
			next_ctrl.transition_rst = 1'b1;
			next_ctrl.pins_hiz       = pin_level;
			next_ctrl.pins_gpio      = !pin_level;
			next_ctrl.sup_resets_en  = 1'b0;
			next_ctrl.reg_low_power  = (state != ST_OSC_WAIT);
			next_ctrl.main_osc_en    = 1'b0;
			next_ctrl.pll_en         = 1'b0;
			next_ctrl.sub_osc_en     = sleep_rtc;
			next_ctrl.hscr_osc_en    = (state == ST_OSC_WAIT);
			next_ctrl.lscr_osc_en    = (state == ST_OSC_WAIT);
		end
		if (state == ST_RESUME) begin
			next_ctrl.hs_run      = 1'b1;
			next_ctrl.main_osc_en = 1'b0;
			next_ctrl.pll_en      = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state             <= ST_RUN;
			o_ctrl            <= CTRL_RUN;
			o_port0_keep_mask <= 8'h00;
		end else begin
			state             <= next_state;
			o_ctrl            <= next_ctrl;
			o_port0_keep_mask <= next_ctrl.transition_rst ? PORT0_KEEP_MASK : 8'h00;
		end
	end

	//------------------------------------------------------------
	// software registers
	//------------------------------------------------------------
	// the resume state clears the standby selection, not this block's own state
	wire clr_sel = (state == ST_RESUME);

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_level <= 1'b0;
			deep_sel  <= 1'b0;
			mode_sel  <= MODE_RST;
		end else if (clr_sel) begin
			pin_level <= 1'b0;
			deep_sel  <= 1'b0;
			mode_sel  <= MODE_RST;
		end else if (wr_stb) begin
			pin_level <= i_wdata[PIN_LVL_B];
			deep_sel  <= i_wdata[DEEP_SEL_B];
			mode_sel  <= i_wdata[1:0];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rtc_mode_enable <= 1'b0;
			wake_en         <= WEN_RST;
			sram_retain     <= 1'b0;
			sleep_rtc       <= 1'b0;
		end else begin
			if (wr_rtcm) begin
				rtc_mode_enable <= i_wdata[0];
			end
			if (wr_wen) begin
				wake_en <= i_wdata[4:0];
			end
			if (wr_ret) begin
				sram_retain <= i_wdata[0];
			end
			if (state == ST_RUN && next_state == ST_ENTER) begin
				sleep_rtc <= rtc_mode_enable;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cause <= '0;
		end else begin
			cause <= (cause & ~(wr_cs ? i_wdata[N_CAUSE-1:0] : '0))
				| (wake ? qual : '0);
		end
	end

	assign o_wake_cause = cause;

	//------------------------------------------------------------
	// read data, one cycle after the strobe
	//------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_stb) begin
			rd_mux[PIN_LVL_B]  = pin_level;
			rd_mux[DEEP_SEL_B] = deep_sel;
			rd_mux[1:0]        = mode_sel;
		end
		if (hit_rtcm) begin
			rd_mux[0] = rtc_mode_enable;
		end
		if (hit_wen) begin
			rd_mux[4:0] = wake_en;
		end
		if (hit_ret) begin
			rd_mux[0] = sram_retain;
		end
		if (hit_cs) begin
			rd_mux[N_CAUSE-1:0] = cause;
		end
		if (hit_st) begin
			rd_mux[0]   = sub_rdy;
			rd_mux[1]   = deep_latched;
			rd_mux[7:2] = state;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= i_re ? rd_mux : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// File: dsps_properties.sv
// port-level assertions for the deep standby power sequencer
`timescale 1ns/10ps
`default_nettype none
module dsps_properties
	import dsps_pkg::*;
#(
	parameter int REG_WAIT_CYCLES = REG_WAIT_CYC,
	parameter int OSC_WAIT_CYCLES = OSC_WAIT_CYC,
	parameter bit HAS_RETENTION   = 1'b1
) (
	input wire logic               i_ref_clk,
	input wire logic               i_rst,
	input wire logic [ADDR_W-1:0]  i_addr,
	input wire logic [31:0]        i_wdata,
	input wire logic               i_we,
	input wire logic               i_re,
	input wire logic [31:0]        o_rdata,
	input wire logic               i_core_deep_sleep_bit,
	input wire logic               i_core_wait,
	input wire logic               o_ordinary_standby_req,
	input wire logic               i_external_reset_pin_n,
	input wire logic               i_lowvolt_reset,
	input wire logic               i_lowvolt_irq,
	input wire logic               i_rtc_irq,
	input wire logic               i_remote_irq,
	input wire logic               i_wake_pin,
	input wire logic               i_sub_osc_ready,
	input wire dsps_ctrl_t         o_ctrl,
	input wire logic [7:0]         o_port0_keep_mask,
	input wire logic [N_CAUSE-1:0] o_wake_cause
);
	// oscillator wait plus the cycle from the expiry pulse to the state change
	localparam int OSC_D = OSC_WAIT_CYCLES + 1;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	key_reads_zero_a: assert property (
		(i_re && i_addr == OFS_STANDBY_CTRL) |=> o_rdata[31:5] == 27'h0)
		else $error("standby control upper bits read nonzero");
	keep_mask_a: assert property (
		o_port0_keep_mask == (o_ctrl.transition_rst ? PORT0_KEEP_MASK : 8'h00))
		else $error("port 0 keep mask disagrees with transition reset");
	aon_power_a: assert property (o_ctrl.aon_pwr)
		else $error("always-on domain lost power");
	deep_clk_off_a: assert property (
		o_ctrl.transition_rst |-> !(o_ctrl.core_clk_en || o_ctrl.ahb_clk_en || o_ctrl.apb_clk_en
		|| o_ctrl.core_pwr || o_ctrl.flash_pwr || o_ctrl.periph_pwr))
		else $error("core or bus clock running in deep standby");
	debug_sup_off_a: assert property (
		o_ctrl.transition_rst |-> !o_ctrl.debug_pwr && !o_ctrl.sup_resets_en)
		else $error("debug power or supervisor resets live in deep standby");
	pin_state_a: assert property (
		o_ctrl.transition_rst |-> o_ctrl.pins_hiz != o_ctrl.pins_gpio)
		else $error("pin state not exactly one of gpio or high impedance");
	entry_cause_a: assert property (
		$rose(o_ctrl.transition_rst) |-> $past(i_core_wait, 2) && $past(i_core_deep_sleep_bit, 2))
		else $error("deep standby entered without a deep sleep wait");
	ordinary_req_a: assert property (
		o_ordinary_standby_req |-> i_core_wait && i_core_deep_sleep_bit && !o_ctrl.transition_rst)
		else $error("ordinary standby request without its cause");
	osc_wait_len_a: assert property (
		($fell(o_ctrl.reg_low_power) && o_ctrl.transition_rst)
		|-> (o_ctrl.hscr_osc_en && o_ctrl.lscr_osc_en) ##OSC_D o_ctrl.hs_run)
		else $error("oscillator wait wrong length or rc oscillators off");
	resume_pulse_a: assert property (
		o_ctrl.hs_run |=> !o_ctrl.hs_run && !o_ctrl.transition_rst)
		else $error("resume pulse longer than one cycle");
	cover property ($rose(o_ctrl.transition_rst));
	cover property (o_ctrl.hs_run);
	cover property (o_ordinary_standby_req);
endmodule
`default_nettype wire

// File: dsps_core_model.sv
// processor core model: sets the deep sleep bit, then issues one wait pulse
`timescale 1ns/10ps
`default_nettype none
module dsps_core_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_go,
	input  wire logic [3:0] i_delay,
	input  wire logic       i_flash_idle,
	input  wire logic       i_core_reset,
	output logic            o_deep_sleep_bit,
	output logic            o_wait
);
	logic       busy;
	logic [3:0] cnt;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_deep_sleep_bit <= 1'b0;
			o_wait <= 1'b0;
			busy <= 1'b0;
			cnt <= 4'h0;
		end else begin
			o_wait <= 1'b0;
			// core state is lost through the transition reset
			if (i_core_reset) begin
				o_deep_sleep_bit <= 1'b0;
			end
			if (i_go && !busy) begin
				o_deep_sleep_bit <= 1'b1;
				busy <= 1'b1;
				cnt <= i_delay;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy && i_flash_idle) begin
				o_wait <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the deep standby power sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import dsps_pkg::*;
	localparam int RW = 20;
	localparam int OW = 10;
	logic              i_ref_clk, i_rst, i_we, i_re, go, deep_bit, core_wait, ord_req;
	logic [ADDR_W-1:0] i_addr;
	logic [31:0]       i_wdata, o_rdata, rnd;
	logic [3:0]        dly;
	logic [5:0]        src_lv;
	logic              i_sub_osc_ready;
	dsps_ctrl_t        o_ctrl, e;
	logic [7:0]        keep_mask;
	logic [5:0]        cause;
	int                n_fail, checks_done, seed, n, m_sc, m_rtc, m_cause;
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	dsps_sequencer #(.REG_WAIT_CYCLES(RW), .OSC_WAIT_CYCLES(OW), .HAS_RETENTION(1'b1)) u_dut (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
		.i_re(i_re), .o_rdata(o_rdata), .i_core_deep_sleep_bit(deep_bit), .i_core_wait(core_wait),
		.o_ordinary_standby_req(ord_req), .i_external_reset_pin_n(!src_lv[0]),
		.i_lowvolt_reset(src_lv[1]), .i_lowvolt_irq(src_lv[2]), .i_rtc_irq(src_lv[3]),
		.i_remote_irq(src_lv[4]), .i_wake_pin(src_lv[5]), .i_sub_osc_ready(i_sub_osc_ready),
		.o_ctrl(o_ctrl), .o_port0_keep_mask(keep_mask), .o_wake_cause(cause));
	dsps_core_model u_core (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_go(go), .i_delay(dly),
		.i_flash_idle(1'b1), .i_core_reset(o_ctrl.transition_rst),
		.o_deep_sleep_bit(deep_bit), .o_wait(core_wait));
	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_we <= 1'b1;
		@(posedge i_ref_clk);
		i_we <= 1'b0;
		if (a == OFS_STANDBY_CTRL && d[31:16] == UNLOCK_KEY) m_sc = d & 32'h17;
		if (a == OFS_RTC_MODE_CTRL && (!d[0] || i_sub_osc_ready)) m_rtc = d[0];
		if (a == OFS_WAKE_CAUSE) m_cause = m_cause & ~d[5:0];
	endtask
	task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_re <= 1'b1;
		@(posedge i_ref_clk);
		i_re <= 1'b0;
		@(negedge i_ref_clk);
		chk(what, exp, o_rdata);
	endtask
	// bit index of o_ctrl, or -1 for any latched wake cause
	task automatic wait_bit(input int b, input int lim);
		n = 0;
		while ((b < 0 ? cause != 6'h0 : o_ctrl[b]) !== 1'b1 && n < lim) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (n >= lim) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic run_case(input bit rtc, input bit standby_pin_level, input bit ret, input logic [4:0] wen,
			input int bad, input int src);
		wr(OFS_RTC_MODE_CTRL, {31'h0, rtc});
		wr(OFS_WAKE_ENABLE, {27'h0, wen});
		wr(OFS_RETENTION, {31'h0, ret});
		rd(OFS_WAKE_CAUSE, "cause clear", 32'(m_cause));
		wr(OFS_STANDBY_CTRL, {UNLOCK_KEY, 11'h0, standby_pin_level, 4'h6});
		rd(OFS_STATUS, "status armed", 32'h7);
		@(posedge i_ref_clk);
		dly <= 4'($random(seed) & 7);
		go <= 1'b1;
		@(posedge i_ref_clk);
		go <= 1'b0;
		wait_bit(5, 40);
		repeat (3) @(negedge i_ref_clk);
		e = '0;
		e.sub_osc_en = rtc;
		e.sram_pwr = ret;
		e.aon_pwr = 1'b1;
		e.transition_rst = 1'b1;
		e.pins_hiz = standby_pin_level;
		e.pins_gpio = !standby_pin_level;
		// regulator mode bit is the designer's own, so it is masked out
		chk("ctrl asleep", 32'(20'(e) & 20'hFFFFB), 32'(20'(o_ctrl) & 20'hFFFFB));
		chk("keep mask", 32'h1F, 32'(keep_mask));
		if (bad >= 0) begin
			@(posedge i_ref_clk);
			src_lv[bad] <= 1'b1;
			repeat (8) @(negedge i_ref_clk);
			chk("ignored source", 32'h20, {26'h0, cause | 6'(o_ctrl.transition_rst) << 5});
			@(posedge i_ref_clk);
			src_lv[bad] <= 1'b0;
			repeat (3) @(posedge i_ref_clk);
		end
		@(posedge i_ref_clk);
		src_lv[src] <= 1'b1;
		wait_bit(-1, 10);
		m_cause = 1 << src;
		chk("wake cause", 32'(m_cause), 32'(cause));
		wait_bit(19, RW + 5);
		chk("regulator wait", RW + 2, n);
		wait_bit(0, OW + 5);
		chk("oscillator wait", OW + 1, n);
		@(negedge i_ref_clk);
		chk("ctrl run", 32'(CTRL_RUN), 32'(o_ctrl));
		m_sc = 0;
		rd(OFS_STANDBY_CTRL, "selection cleared", 32'(m_sc));
		rd(OFS_WAKE_CAUSE, "cause kept", 32'(m_cause));
		wr(OFS_WAKE_CAUSE, 32'h3F);
		src_lv[src] <= 1'b0;
	endtask
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		{i_rst, i_we, i_re, go, i_sub_osc_ready} = 5'h10;
		{i_addr, i_wdata, dly, src_lv} = '0;
		{n_fail, checks_done, m_sc, m_rtc, m_cause} = '0;
		seed = 32'h9E30;
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(OFS_STATUS, "status reset", 32'h4);
		wr(OFS_RTC_MODE_CTRL, 32'h1);
		rd(OFS_RTC_MODE_CTRL, "rtc refused", 32'(m_rtc));
		wr(8'h20, 32'hFFFF_FFFF);
		i_sub_osc_ready <= 1'b1;
		rd(8'h20, "unmapped", 32'h0);
		rd(OFS_STATUS, "status ready", 32'h5);
		rnd = $random(seed);
		wr(OFS_STANDBY_CTRL, {rnd[31:16] ^ (rnd[31:16] == UNLOCK_KEY), 16'h0016});
		rd(OFS_STANDBY_CTRL, "no key", 32'(m_sc));
		@(posedge i_ref_clk);
		go <= 1'b1;
		@(posedge i_ref_clk);
		go <= 1'b0;
		n = 0;
		while (core_wait !== 1'b1 && n < 20) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk("ordinary standby", 32'h1, {31'h0, ord_req});
		repeat (4) @(negedge i_ref_clk);
		chk("stay running", 32'h0, {31'h0, o_ctrl.transition_rst});
		run_case(1, 0, 1, 5'h1F, -1, 3);
		run_case(0, 1, 0, 5'h1F, 3, 5);
		run_case(0, 0, 1, 5'h1F, 4, 2);
		run_case(1, 1, 0, 5'h0B, 2, 0);
		run_case(1, 0, 0, 5'h1F, -1, 1);
		run_case(1, 1, 1, 5'h1F, -1, 4);
		give_verdict();
	end
endmodule
bind dsps_sequencer dsps_properties #(.REG_WAIT_CYCLES(REG_WAIT_CYCLES),
	.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES), .HAS_RETENTION(HAS_RETENTION)) u_props (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
	.i_re(i_re), .o_rdata(o_rdata), .i_core_deep_sleep_bit(i_core_deep_sleep_bit),
	.i_core_wait(i_core_wait), .o_ordinary_standby_req(o_ordinary_standby_req),
	.i_external_reset_pin_n(i_external_reset_pin_n), .i_lowvolt_reset(i_lowvolt_reset),
	.i_lowvolt_irq(i_lowvolt_irq), .i_rtc_irq(i_rtc_irq), .i_remote_irq(i_remote_irq),
	.i_wake_pin(i_wake_pin), .i_sub_osc_ready(i_sub_osc_ready), .o_ctrl(o_ctrl),
	.o_port0_keep_mask(o_port0_keep_mask), .o_wake_cause(o_wake_cause));
`default_nettype wire
